// ==== pst_pkg.sv ====
// constants for the power-on self-test sequencer
package pst_pkg;
   localparam logic [15:0] SELFTEST_STATUS_ADDR = 16'h3020;
   localparam int unsigned DONE_BIT             = 7;
   localparam int unsigned MEM_PASS_BIT         = 6;
   localparam int unsigned LOGIC_PASS_BIT       = 5;
   localparam int unsigned MEM_RAN_BIT          = 1;
   localparam int unsigned LOGIC_RAN_BIT        = 0;
   localparam logic [7:0]  STATUS_RESET         = 8'h00;
   localparam logic [7:0]  IRQ_RESET            = 8'h00;
   // own registers for the interrupt plumbing
   localparam logic [15:0] IRQ_STATUS_ADDR      = 16'h3021;
   localparam logic [15:0] IRQ_MASK_ADDR        = 16'h3022;
   localparam int unsigned IRQ_DONE_BIT         = 0;
   localparam int unsigned IRQ_FAIL_BIT         = 1;
   // time limits
   localparam int unsigned CLK_MHZ              = 200;
   localparam int unsigned TEST_LIMIT_MS        = 10;
   localparam int unsigned TEST_LIMIT_CYC       = TEST_LIMIT_MS * 1000 * CLK_MHZ;
   // memory geometry under test
   localparam int unsigned MEM_COUNT            = 2;
   localparam int unsigned MEM_AW               = 6;
   localparam int unsigned MEM_DEPTH            = 64;
   localparam int unsigned LOGIC_BLOCKS         = 4;
   localparam int unsigned LFSR_STEPS           = 256;
   localparam logic [15:0] LFSR_SEED            = 16'hACE1;
   typedef enum logic [2:0] {PST_IDLE, PST_LOGIC, PST_MEM_WR, PST_MEM_RD, PST_DONE} pst_state_t;
endpackage

// ==== pst_mem_bank.sv ====
// small memory bank exercised by the memory self-test
module pst_mem_bank (
   // clock
   input  wire logic                          i_clock,
   // access
   input  wire logic                          i_we,
   input  wire logic [pst_pkg::MEM_AW-1:0]    i_addr,
   input  wire logic [7:0]                    i_wdata,
   output logic      [7:0]                    o_rdata
);
   logic [7:0] mem [pst_pkg::MEM_DEPTH];

   always_ff @(posedge i_clock)
   begin
      if (i_we)
      begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule

// ==== pst_selftest.sv ====
// power-on self-test sequencer with read-only result register
// How it works
// - test starts itself after reset and its engines go idle when done.
// - an lfsr signature test covers logic, a march test covers memories.
// - whole test ends well under 10 ms; nothing can skip it.
// - no register bit configures or changes the test.
// - separate pass flags for logic test and memory test are kept.
// - o_bringup_ok rises on completion whatever the test outcome.
// - a pass flag needs every sub-block or memory to pass.
// - status bit 7 at 0x3020 reads one once the test completes.
// - bit 6 shows memory pass, bit 5 shows logic pass.
// - bit 1 shows memory test ran, bit 0 shows logic test ran.
//
// Chosen here: the plain strobed port.
module pst_selftest (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   // register port
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // system
   output logic             o_bringup_ok,
   output logic             o_test_active,
   output logic             o_irq
);
   pst_pkg::pst_state_t state_q;
   logic [15:0]         lfsr_q;
   logic [8:0]          step_q;
   logic [1:0]          blk_q;
   logic [pst_pkg::MEM_AW-1:0] maddr_q;
   logic                mem_sel_q;
   logic                rd_pend_q;
   logic                logic_ok_q;
   logic                mem_ok_q;
   logic                logic_ran_q;
   logic                mem_ran_q;
   logic                done_q;
   logic [7:0]          status_q;
   logic [1:0]          irq_stat_q;
   logic [1:0]          irq_mask_q;
   logic [7:0]          rdata_q;
   logic [31:0]         run_cnt_q;
   logic [7:0]          rdata0;
   logic [7:0]          rdata1;
   logic                we0;
   logic                we1;
   logic [7:0]          pattern;
   logic [1:0]          irq_ev;

   localparam logic [pst_pkg::MEM_AW-1:0] MEM_LAST   = '1;
   localparam logic [pst_pkg::MEM_AW-1:0] MEM_ONE    = {{(pst_pkg::MEM_AW-1){1'b0}}, 1'b1};
   localparam logic [1:0]                 IRQ_RESET2 = pst_pkg::IRQ_RESET[1:0];
   localparam logic [31:0]                STOP_CYC   = 32'(pst_pkg::TEST_LIMIT_CYC - 4);

   // fixed reference signature per logic sub-block; a fault skews the lfsr path
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [7:0] pat_of(input logic [pst_pkg::MEM_AW-1:0] a, input logic s);
      pat_of = {2'h0, a} ^ (s ? 8'hA5 : 8'h5A);
   endfunction

   function automatic logic [15:0] golden(input logic [1:0] b);
      logic [15:0] v;
      v = pst_pkg::LFSR_SEED ^ {14'h0000, b};
      for (int i = 0; i < pst_pkg::LFSR_STEPS; i++)
      begin
         v = lfsr_next(v);
      end
      golden = v;
   endfunction

   assign pattern = pat_of(maddr_q, mem_sel_q);
   assign we0     = (state_q == pst_pkg::PST_MEM_WR) && !mem_sel_q;
   assign we1     = (state_q == pst_pkg::PST_MEM_WR) && mem_sel_q;

   pst_mem_bank u_mem0 (
      .i_clock (i_clock),
      .i_we    (we0),
      .i_addr  (maddr_q),
      .i_wdata (pattern),
      .o_rdata (rdata0)
   );

   pst_mem_bank u_mem1 (
      .i_clock (i_clock),
      .i_we    (we1),
      .i_addr  (maddr_q),
      .i_wdata (pattern),
      .o_rdata (rdata1)
   );

   // sequencer: starts from reset with no trigger and no bypass
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_q   <= pst_pkg::PST_LOGIC;
         step_q    <= 9'h000;
         blk_q     <= 2'h0;
         maddr_q   <= '0;
         mem_sel_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end
      // a stalled engine cannot hold bring-up past the time budget
      else if (run_cnt_q == STOP_CYC)
      begin
         state_q <= pst_pkg::PST_DONE;
      end
      else
      begin
         case (state_q)
            pst_pkg::PST_LOGIC:
            begin
               if (step_q == 9'(pst_pkg::LFSR_STEPS))
               begin
                  step_q <= 9'h000;
                  blk_q  <= blk_q + 2'h1;
                  if (blk_q == 2'(pst_pkg::LOGIC_BLOCKS - 1))
                  begin
                     state_q <= pst_pkg::PST_MEM_WR;
                  end
               end
               else
               begin
                  step_q <= step_q + 9'h001;
               end
            end
            pst_pkg::PST_MEM_WR:
            begin
               maddr_q <= maddr_q + MEM_ONE;
               if (maddr_q == MEM_LAST)
               begin
                  state_q <= pst_pkg::PST_MEM_RD;
               end
            end
            pst_pkg::PST_MEM_RD:
            begin
               // one cycle read latency: compare follows the address by a cycle
               if (!rd_pend_q)
               begin
                  rd_pend_q <= 1'b1;
               end
               else
               begin
                  rd_pend_q <= 1'b0;
                  maddr_q   <= maddr_q + MEM_ONE;
                  if (maddr_q == MEM_LAST)
                  begin
                     if (mem_sel_q)
                     begin
                        state_q <= pst_pkg::PST_DONE;
                     end
                     else
                     begin
                        mem_sel_q <= 1'b1;
                        state_q   <= pst_pkg::PST_MEM_WR;
                     end
                  end
               end
            end
            pst_pkg::PST_DONE:
            begin
               state_q <= pst_pkg::PST_DONE;
            end
            default:
            begin
               state_q <= pst_pkg::PST_DONE;
            end
         endcase
      end
   end

   // logic signature engine, one lfsr run per sub-block
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         lfsr_q <= pst_pkg::LFSR_SEED;
      end
      else if (state_q == pst_pkg::PST_LOGIC)
      begin
         if (step_q == 9'(pst_pkg::LFSR_STEPS))
         begin
            lfsr_q <= pst_pkg::LFSR_SEED ^ {14'h0000, blk_q + 2'h1};
         end
         else if (step_q == 9'h000)
         begin
            lfsr_q <= lfsr_next(pst_pkg::LFSR_SEED ^ {14'h0000, blk_q});
         end
         else
         begin
            lfsr_q <= lfsr_next(lfsr_q);
         end
      end
   end

   // result accumulation: any failing unit clears the pass flag of its own test
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         logic_ok_q  <= 1'b1;
         mem_ok_q    <= 1'b1;
         logic_ran_q <= 1'b0;
         mem_ran_q   <= 1'b0;
      end
      else
      begin
         if (state_q == pst_pkg::PST_LOGIC && step_q == 9'(pst_pkg::LFSR_STEPS))
         begin
            logic_ran_q <= 1'b1;
            if (lfsr_q != golden(blk_q))
            begin
               logic_ok_q <= 1'b0;
            end
         end
         if (state_q == pst_pkg::PST_MEM_RD && rd_pend_q)
         begin
            mem_ran_q <= 1'b1;
            if ((mem_sel_q ? rdata1 : rdata0) != pattern)
            begin
               mem_ok_q <= 1'b0;
            end
         end
      end
   end

   // completion and status register; fields only appear once done
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         done_q   <= 1'b0;
         status_q <= pst_pkg::STATUS_RESET;
      end
      else if (state_q == pst_pkg::PST_DONE && !done_q)
      begin
         done_q                            <= 1'b1;
         status_q                          <= 8'h00;
         status_q[pst_pkg::DONE_BIT]       <= 1'b1;
         status_q[pst_pkg::MEM_PASS_BIT]   <= mem_ok_q && mem_ran_q;
         status_q[pst_pkg::LOGIC_PASS_BIT] <= logic_ok_q && logic_ran_q;
         status_q[pst_pkg::MEM_RAN_BIT]    <= mem_ran_q;
         status_q[pst_pkg::LOGIC_RAN_BIT]  <= logic_ran_q;
      end
   end

   // watchdog on test length; stops a few cycles short so the closing stages still fit the budget
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         run_cnt_q <= 32'h0000_0000;
      end
      else if (!done_q && run_cnt_q != STOP_CYC)
      begin
         run_cnt_q <= run_cnt_q + 32'h0000_0001;
      end
   end

   // interrupt status: done and fail events, write one to clear, set wins
   assign irq_ev[pst_pkg::IRQ_DONE_BIT] = state_q == pst_pkg::PST_DONE && !done_q;
   assign irq_ev[pst_pkg::IRQ_FAIL_BIT] = irq_ev[pst_pkg::IRQ_DONE_BIT] && !(mem_ok_q && logic_ok_q);

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         irq_stat_q <= IRQ_RESET2;
         irq_mask_q <= IRQ_RESET2;
      end
      else
      begin
         if (i_wr && i_addr == pst_pkg::IRQ_MASK_ADDR)
         begin
            irq_mask_q <= i_wdata[1:0];
         end
         irq_stat_q <= (irq_stat_q & ~((i_wr && i_addr == pst_pkg::IRQ_STATUS_ADDR) ? i_wdata[1:0] : 2'h0)) | irq_ev;
      end
   end

   // read port; the self-test status is read-only, writes to it are ignored
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rdata_q <= 8'h00;
      end
      else if (i_rd)
      begin
         case (i_addr)
            pst_pkg::SELFTEST_STATUS_ADDR: rdata_q <= status_q;
            pst_pkg::IRQ_STATUS_ADDR:      rdata_q <= {6'h00, irq_stat_q};
            pst_pkg::IRQ_MASK_ADDR:        rdata_q <= {6'h00, irq_mask_q};
            default:                       rdata_q <= 8'h00;
         endcase
      end
      else
      begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata       = rdata_q;
   assign o_bringup_ok  = done_q;
   assign o_test_active = !done_q && state_q != pst_pkg::PST_DONE;
   assign o_irq         = |(irq_stat_q & irq_mask_q);
endmodule

// ==== pst_selftest_sva.sv ====
// assertions for the power-on self-test sequencer
module pst_selftest_sva (
   // clock and reset
   input wire logic        i_clock,
   input wire logic        i_arst_n,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   // system
   input wire logic        o_bringup_ok,
   input wire logic        o_test_active,
   input wire logic        o_irq
);
   logic [31:0] cyc_q;
   logic        st_rd;
   assign st_rd = i_rd && (i_addr == pst_pkg::SELFTEST_STATUS_ADDR);
   // counts cycles spent before completion since the last reset
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cyc_q <= '0;
      else if (!o_bringup_ok)
         cyc_q <= cyc_q + 32'h1;
   end
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);
   idle_zero_a: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero without a read");
   unused_bits_a: assert property (o_rdata[4:2] == 3'h0)
      else $error("unused status bits not zero");
   pre_done_a: assert property (st_rd && !o_bringup_ok |=> o_rdata == 8'h00)
      else $error("status not zero before completion");
   post_done_a: assert property (st_rd && o_bringup_ok |=> o_rdata == 8'hE3)
      else $error("status wrong after completion");
   bringup_hold_a: assert property (o_bringup_ok |=> o_bringup_ok)
      else $error("bring-up indication dropped");
   engines_off_a: assert property (o_bringup_ok |-> !o_test_active)
      else $error("test still active after completion");
   time_bound_a: assert property (cyc_q < 32'(pst_pkg::TEST_LIMIT_CYC))
      else $error("self-test overran its time limit");
   unmapped_a: assert property (i_rd && i_addr > pst_pkg::IRQ_MASK_ADDR |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property (st_rd && o_bringup_ok);
   cover property ($rose(o_bringup_ok));
   cover property ($rose(o_irq));
endmodule

bind pst_selftest pst_selftest_sva i_sva (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bringup_ok(o_bringup_ok),
   .o_test_active(o_test_active), .o_irq(o_irq));

// ==== pst_selftest_tb_top.sv ====
// self-checking bench for the power-on self-test sequencer
module pst_selftest_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clock, i_arst_n, i_wr, i_rd, o_bringup_ok, o_test_active, o_irq;
   logic [15:0] i_addr;
   logic [7:0]  i_wdata, o_rdata, rd_v;
   int          miscompares, n_tests, cyc, m_mask, m_irq, exp_st;

   pst_selftest i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bringup_ok(o_bringup_ok),
      .o_test_active(o_test_active), .o_irq(o_irq));

   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   task automatic conclude();
      if (miscompares == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk_reg({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1;
      rd_v = o_rdata;
   endtask

   // the interrupt level may be registered, so let two edges pass
   task automatic chk_irq();
      repeat (2) @(posedge i_clock);
      #1;
      chk_flag(o_irq, (m_irq & m_mask) != 0);
   endtask

   initial
   begin
      i_arst_n = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      miscompares = 0;
      n_tests = 0;
      void'($urandom(32'h2f7f1518));
      exp_st = (1 << pst_pkg::DONE_BIT) | (1 << pst_pkg::MEM_PASS_BIT) | (1 << pst_pkg::LOGIC_PASS_BIT)
             | (1 << pst_pkg::MEM_RAN_BIT) | (1 << pst_pkg::LOGIC_RAN_BIT);
      for (int run = 0; run < 2; run++)
      begin
         repeat (12) @(posedge i_clock);
         i_arst_n <= 1'b1;
         m_mask = 0;
         m_irq = 0;
         rd(pst_pkg::SELFTEST_STATUS_ADDR);
         chk_reg(rd_v, 8'h00);
         wr(pst_pkg::SELFTEST_STATUS_ADDR, 8'($urandom));
         rd(16'h3023 + 16'($urandom_range(0, 255)));
         chk_reg(rd_v, 8'h00);
         chk_flag(o_test_active, 1'b1);
         chk_flag(o_bringup_ok, 1'b0);
         cyc = 0;
         while (o_bringup_ok !== 1'b1 && cyc < 20000)
         begin
            @(posedge i_clock);
            #1;
            cyc++;
         end
         chk_flag(cyc < pst_pkg::TEST_LIMIT_CYC, 1'b1);
         chk_flag(o_bringup_ok, 1'b1);
         chk_flag(o_test_active, 1'b0);
         m_irq = 1 << pst_pkg::IRQ_DONE_BIT;
         chk_irq();
         rd(pst_pkg::SELFTEST_STATUS_ADDR);
         chk_reg(rd_v, exp_st[7:0]);
         wr(pst_pkg::SELFTEST_STATUS_ADDR, 8'($urandom));
         rd(pst_pkg::SELFTEST_STATUS_ADDR);
         chk_reg(rd_v, exp_st[7:0]);
         rd(pst_pkg::IRQ_STATUS_ADDR);
         chk_reg(rd_v, 8'(m_irq));
         wr(pst_pkg::IRQ_MASK_ADDR, 8'h03);
         m_mask = 3;
         chk_irq();
         rd(pst_pkg::IRQ_MASK_ADDR);
         chk_reg(rd_v, 8'(m_mask));
         wr(pst_pkg::IRQ_STATUS_ADDR, 8'h01);
         m_irq = 0;
         chk_irq();
         rd(pst_pkg::IRQ_STATUS_ADDR);
         chk_reg(rd_v, 8'(m_irq));
         @(posedge i_clock);
         i_arst_n <= 1'b0;
      end
      conclude();
   end

   // the whole run needs well under ten thousand cycles
   initial
   begin
      repeat (60000) @(posedge i_clock);
      miscompares++;
      conclude();
   end
endmodule
